/* File: rtl/apl_consts.vh */
// constants for the address port pin logic block
`ifndef APL_CONSTS_VH
`define APL_CONSTS_VH

// ===========================================================
// register word offsets (byte addresses, wishbone)
`define APL_OFF_MODE        8'h00
`define APL_OFF_PA_DIR      8'h04
`define APL_OFF_PA_OUT      8'h08
`define APL_OFF_PA_ODRAIN   8'h0c
`define APL_OFF_PA_PULLUP   8'h10
`define APL_OFF_PA_PIN      8'h14
`define APL_OFF_PB_DIR      8'h18
`define APL_OFF_PB_OUT      8'h1c
`define APL_OFF_PB_PULLUP   8'h20
`define APL_OFF_PB_PIN      8'h24
`define APL_OFF_PC_DIR      8'h28
`define APL_OFF_PC_OUT      8'h2c
`define APL_OFF_PC_PULLUP   8'h30
`define APL_OFF_PC_PIN      8'h34
`define APL_OFF_PF_LATCH    8'h38
`define APL_OFF_PF_DIR      8'h3c
`define APL_OFF_PF_PIN      8'h40
`define APL_OFF_STATUS      8'h44

// ===========================================================
// mode register fields
`define APL_MODE_LSB        0
`define APL_MODE_MSB        2
`define APL_EXTERNAL_EXPANSION_ENABLE_BIT        3
`define APL_SWSTBY_BIT      4

// ===========================================================
// operating mode codes
`define APL_MODE1           3'h1
`define APL_MODE2           3'h2
`define APL_MODE4           3'h4
`define APL_MODE7           3'h7

// ===========================================================
// reset values
`define APL_RST_BYTE        8'h00
`define APL_RST_MODE        3'h7
`define APL_RST_CTRL        5'h07

`endif

/* File: rtl/apl_sync8.v */
// two flip-flop synchroniser for an 8-bit pin group
`timescale 1ns/1ns
module apl_sync8 #(
    parameter W = 8
) (
    input  wire         core_clk, // system clock
    input  wire         rst,      // async reset, active high
    input  wire [W-1:0] d_in,     // asynchronous pin levels
    output reg  [W-1:0] q_out     // synchronised levels
);
    reg [W-1:0] meta_reg;

    // first stage feeds only the second
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            meta_reg <= {W{1'b0}};
            q_out    <= {W{1'b0}};
        end else begin
            meta_reg <= d_in;
            q_out    <= meta_reg;
        end
    end
endmodule

/* File: rtl/apl_port.v */
// address port pin logic: ports a, b, c as address or i/o, port f latch
//
// The Wishbone slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`include "apl_consts.vh"

// Overview of operation
// - ports a-c carry address in modes 1/2 (port a on pins 4-0 only), address or i/o in mode 4 and mode 7 with expansion, i/o only otherwise.
// - port a has pull-ups and open-drain outputs; pins 7-5 are interrupt inputs always, pin 4 except in modes 1/2.
// - port c pull-ups work only in modes 4 and 7.
// - every port c pin has its own pull-up control bit.
// - in modes 4/7 outside hardware standby a port c pull-up is on exactly when its direction bit is 0 and its control bit is 1.
// - in modes 1/2 port c pull-ups are always off, in every state.
// - in modes 4/7 the chosen pull-up state also holds in software standby.
// - port f latch holds one read/write output bit per pin, cleared at reset, driven when the pin's direction bit is 1.
// - port f pin-state reads give the latch for output pins and the pin level for input pins; writes do nothing.
module apl_port (
    input  wire        core_clk,     // system clock, 10 mhz
    input  wire        rst,          // async reset, active high
    input  wire        hw_standby,   // hardware standby pin level
    input  wire [23:0] addr_in,      // external address from bus controller
    input  wire        addr_valid,   // bus controller drives an address
    input  wire [31:0] wb_adr_i,     // wishbone address
    input  wire [31:0] wb_dat_i,     // wishbone write data
    output reg  [31:0] wb_dat_o,     // wishbone read data
    input  wire        wb_we_i,      // wishbone write enable
    input  wire [3:0]  wb_sel_i,     // wishbone byte selects
    input  wire        wb_cyc_i,     // wishbone cycle
    input  wire        wb_stb_i,     // wishbone strobe
    output reg         wb_ack_o,     // wishbone acknowledge
    output reg         wb_err_o,     // wishbone error, unmapped address
    input  wire [7:0]  pa_in,        // port a pin levels
    output reg  [7:0]  pa_out,       // port a output values
    output reg  [7:0]  pa_oe,        // port a output enables
    output reg  [7:0]  pa_pullup,    // port a pull-up enables
    input  wire [7:0]  pb_in,        // port b pin levels
    output reg  [7:0]  pb_out,       // port b output values
    output reg  [7:0]  pb_oe,        // port b output enables
    output reg  [7:0]  pb_pullup,    // port b pull-up enables
    input  wire [7:0]  pc_in,        // port c pin levels
    output reg  [7:0]  pc_out,       // port c output values
    output reg  [7:0]  pc_oe,        // port c output enables
    output reg  [7:0]  pc_pullup,    // port c pull-up enables
    input  wire [7:0]  pf_in,        // port f pin levels
    output reg  [7:0]  pf_out,       // port f output values
    output reg  [7:0]  pf_oe,        // port f output enables
    output reg  [7:0]  irq_req       // synchronised interrupt request inputs 7..4, bits 3..0 held low
);
    // ===========================================================
    // registers
    reg  [2:0] mode_reg;
    reg        external_expansion_enable_reg;
    reg        swstby_reg;
    reg  [7:0] pa_dir_reg, pa_dat_reg, pa_od_reg, pa_pu_reg;
    reg  [7:0] pb_dir_reg, pb_dat_reg, pb_pu_reg;
    reg  [7:0] pc_dir_reg, pc_dat_reg, pc_pu_reg;
    reg  [7:0] port_f_output_latch, pf_dir_reg;
    reg  [23:0] addr_reg;
    reg        addr_v_reg;
    reg        hwsb_meta_reg, hwsb_reg;
    reg  [31:0] rd_next;
    reg        hit_next;

    wire [7:0] pa_sync, pb_sync, pc_sync, pf_sync;

    // ===========================================================
    // pin synchronisers
    apl_sync8 #(.W(8)) u_sync_a (.core_clk(core_clk), .rst(rst), .d_in(pa_in), .q_out(pa_sync));
    apl_sync8 #(.W(8)) u_sync_b (.core_clk(core_clk), .rst(rst), .d_in(pb_in), .q_out(pb_sync));
    apl_sync8 #(.W(8)) u_sync_c (.core_clk(core_clk), .rst(rst), .d_in(pc_in), .q_out(pc_sync));
    apl_sync8 #(.W(8)) u_sync_f (.core_clk(core_clk), .rst(rst), .d_in(pf_in), .q_out(pf_sync));

    // hardware standby pin synchroniser
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            hwsb_meta_reg <= 1'b0;
            hwsb_reg      <= 1'b0;
        end else begin
            hwsb_meta_reg <= hw_standby;
            hwsb_reg      <= hwsb_meta_reg;
        end
    end

    // ===========================================================
    // mode decode
    wire addr_only = (mode_reg == `APL_MODE1) || (mode_reg == `APL_MODE2);
    wire mixed     = (mode_reg == `APL_MODE4) || ((mode_reg == `APL_MODE7) && external_expansion_enable_reg);
    wire pc_pu_ok  = (mode_reg == `APL_MODE4) || (mode_reg == `APL_MODE7);

    // ===========================================================
    // read mux, if/else-if decode
    always @* begin
        rd_next  = 32'h0000_0000;
        hit_next = 1'b1;
        if (wb_adr_i[7:0] == `APL_OFF_MODE) begin
            rd_next[4:0] = {swstby_reg, external_expansion_enable_reg, mode_reg};
        end else if (wb_adr_i[7:0] == `APL_OFF_PA_DIR) begin
            rd_next[7:0] = pa_dir_reg;
        end else if (wb_adr_i[7:0] == `APL_OFF_PA_OUT) begin
            rd_next[7:0] = pa_dat_reg;
        end else if (wb_adr_i[7:0] == `APL_OFF_PA_ODRAIN) begin
            rd_next[7:0] = pa_od_reg;
        end else if (wb_adr_i[7:0] == `APL_OFF_PA_PULLUP) begin
            rd_next[7:0] = pa_pu_reg;
        end else if (wb_adr_i[7:0] == `APL_OFF_PA_PIN) begin
            rd_next[7:0] = (pa_dir_reg & pa_dat_reg) | (~pa_dir_reg & pa_sync);
        end else if (wb_adr_i[7:0] == `APL_OFF_PB_DIR) begin
            rd_next[7:0] = pb_dir_reg;
        end else if (wb_adr_i[7:0] == `APL_OFF_PB_OUT) begin
            rd_next[7:0] = pb_dat_reg;
        end else if (wb_adr_i[7:0] == `APL_OFF_PB_PULLUP) begin
            rd_next[7:0] = pb_pu_reg;
        end else if (wb_adr_i[7:0] == `APL_OFF_PB_PIN) begin
            rd_next[7:0] = (pb_dir_reg & pb_dat_reg) | (~pb_dir_reg & pb_sync);
        end else if (wb_adr_i[7:0] == `APL_OFF_PC_DIR) begin
            rd_next[7:0] = pc_dir_reg;
        end else if (wb_adr_i[7:0] == `APL_OFF_PC_OUT) begin
            rd_next[7:0] = pc_dat_reg;
        end else if (wb_adr_i[7:0] == `APL_OFF_PC_PULLUP) begin
            rd_next[7:0] = pc_pu_reg;
        end else if (wb_adr_i[7:0] == `APL_OFF_PC_PIN) begin
            rd_next[7:0] = (pc_dir_reg & pc_dat_reg) | (~pc_dir_reg & pc_sync);
        end else if (wb_adr_i[7:0] == `APL_OFF_PF_LATCH) begin
            rd_next[7:0] = port_f_output_latch;
        end else if (wb_adr_i[7:0] == `APL_OFF_PF_DIR) begin
            rd_next[7:0] = pf_dir_reg;
        end else if (wb_adr_i[7:0] == `APL_OFF_PF_PIN) begin
            rd_next[7:0] = (pf_dir_reg & port_f_output_latch) | (~pf_dir_reg & pf_sync);
        end else if (wb_adr_i[7:0] == `APL_OFF_STATUS) begin
            rd_next[2:0] = {hwsb_reg, mixed, addr_only};
        end else begin
            hit_next = 1'b0;
        end
        if (wb_adr_i[31:8] != 24'h000000) begin
            hit_next = 1'b0;
        end
    end

    wire req   = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    wire wr_ok = req && wb_we_i && hit_next && wb_sel_i[0];

    // ===========================================================
    // wishbone slave: one wait cycle, ack or err next edge
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req && hit_next;
            wb_err_o <= req && !hit_next;
            wb_dat_o <= (req && hit_next && !wb_we_i) ? rd_next : 32'h0000_0000;
        end
    end

    // register writes, low byte lane only; pin-state words ignore writes
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mode_reg            <= `APL_RST_MODE;
            external_expansion_enable_reg            <= 1'b0;
            swstby_reg          <= 1'b0;
            pa_dir_reg          <= `APL_RST_BYTE;
            pa_dat_reg          <= `APL_RST_BYTE;
            pa_od_reg           <= `APL_RST_BYTE;
            pa_pu_reg           <= `APL_RST_BYTE;
            pb_dir_reg          <= `APL_RST_BYTE;
            pb_dat_reg          <= `APL_RST_BYTE;
            pb_pu_reg           <= `APL_RST_BYTE;
            pc_dir_reg          <= `APL_RST_BYTE;
            pc_dat_reg          <= `APL_RST_BYTE;
            pc_pu_reg           <= `APL_RST_BYTE;
            port_f_output_latch <= `APL_RST_BYTE;
            pf_dir_reg          <= `APL_RST_BYTE;
        end else if (wr_ok) begin
            if (wb_adr_i[7:0] == `APL_OFF_MODE) begin
                mode_reg   <= wb_dat_i[`APL_MODE_MSB:`APL_MODE_LSB];
                external_expansion_enable_reg   <= wb_dat_i[`APL_EXTERNAL_EXPANSION_ENABLE_BIT];
                swstby_reg <= wb_dat_i[`APL_SWSTBY_BIT];
            end else if (wb_adr_i[7:0] == `APL_OFF_PA_DIR) begin
                pa_dir_reg <= wb_dat_i[7:0];
            end else if (wb_adr_i[7:0] == `APL_OFF_PA_OUT) begin
                pa_dat_reg <= wb_dat_i[7:0];
            end else if (wb_adr_i[7:0] == `APL_OFF_PA_ODRAIN) begin
                pa_od_reg <= wb_dat_i[7:0];
            end else if (wb_adr_i[7:0] == `APL_OFF_PA_PULLUP) begin
                pa_pu_reg <= wb_dat_i[7:0];
            end else if (wb_adr_i[7:0] == `APL_OFF_PB_DIR) begin
                pb_dir_reg <= wb_dat_i[7:0];
            end else if (wb_adr_i[7:0] == `APL_OFF_PB_OUT) begin
                pb_dat_reg <= wb_dat_i[7:0];
            end else if (wb_adr_i[7:0] == `APL_OFF_PB_PULLUP) begin
                pb_pu_reg <= wb_dat_i[7:0];
            end else if (wb_adr_i[7:0] == `APL_OFF_PC_DIR) begin
                pc_dir_reg <= wb_dat_i[7:0];
            end else if (wb_adr_i[7:0] == `APL_OFF_PC_OUT) begin
                pc_dat_reg <= wb_dat_i[7:0];
            end else if (wb_adr_i[7:0] == `APL_OFF_PC_PULLUP) begin
                pc_pu_reg <= wb_dat_i[7:0];
            end else if (wb_adr_i[7:0] == `APL_OFF_PF_LATCH) begin
                port_f_output_latch <= wb_dat_i[7:0];
            end else if (wb_adr_i[7:0] == `APL_OFF_PF_DIR) begin
                pf_dir_reg <= wb_dat_i[7:0];
            end
        end
    end

    // capture the bus controller address
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            addr_reg   <= 24'h000000;
            addr_v_reg <= 1'b0;
        end else begin
            addr_reg   <= addr_in;
            addr_v_reg <= addr_valid;
        end
    end

    // ===========================================================
    // pin drive: address in modes 1/2, address on output pins while bus active in mixed modes
    wire        drive_addr = addr_only || (mixed && addr_v_reg);
    wire [7:0]  pa_dat_oe  = pa_dir_reg & ~(pa_od_reg & pa_dat_reg);
    wire [7:0]  pc_pu_next = (pc_pu_ok && !hwsb_reg) ? (~pc_dir_reg & pc_pu_reg) : 8'h00;
    // per-pin address masks; in mixed modes input pins keep their pull-ups and are never driven
    wire [7:0]  pa_amask   = addr_only ? 8'h1f : (drive_addr ? pa_dir_reg : 8'h00); // pins 7..5 stay i/o in 1/2
    wire [7:0]  pb_amask   = addr_only ? 8'hff : (drive_addr ? pb_dir_reg : 8'h00);
    wire [7:0]  pc_amask   = addr_only ? 8'hff : (drive_addr ? pc_dir_reg : 8'h00);

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pa_out    <= 8'h00;
            pa_oe     <= 8'h00;
            pa_pullup <= 8'h00;
            pb_out    <= 8'h00;
            pb_oe     <= 8'h00;
            pb_pullup <= 8'h00;
            pc_out    <= 8'h00;
            pc_oe     <= 8'h00;
            pc_pullup <= 8'h00;
            pf_out    <= 8'h00;
            pf_oe     <= 8'h00;
            irq_req   <= 8'h00;
        end else begin
            pa_out    <= (addr_reg[23:16] & pa_amask) | (pa_dat_reg & ~pa_od_reg & ~pa_amask);
            pa_oe     <= pa_amask | pa_dat_oe;
            pb_out    <= (addr_reg[15:8] & pb_amask) | (pb_dat_reg & ~pb_amask);
            pb_oe     <= pb_amask | pb_dir_reg;
            pc_out    <= (addr_reg[7:0] & pc_amask) | (pc_dat_reg & ~pc_amask);
            pc_oe     <= pc_amask | pc_dir_reg;
            pa_pullup <= pa_pu_reg & ~pa_dir_reg & ~pa_amask;
            pb_pullup <= addr_only ? 8'h00 : (pb_pu_reg & ~pb_dir_reg);
            pc_pullup <= pc_pu_next;
            pf_out    <= port_f_output_latch;
            pf_oe     <= pf_dir_reg;
            // irq 7..5 in every mode, irq 4 not in modes 1/2
            irq_req   <= {pa_sync[7:5], pa_sync[4] & ~addr_only, 4'h0};
        end
    end
endmodule

/* File: tb/apl_port_checker.sv */
// assertion checker for the address port pin logic block
`timescale 1ns/1ns
module apl_port_checker (
    input wire        core_clk,   // system clock
    input wire        rst,        // async reset, active high
    input wire        hw_standby, // hardware standby level
    input wire        wb_cyc_i,   // wishbone cycle
    input wire        wb_stb_i,   // wishbone strobe
    input wire        wb_ack_o,   // wishbone acknowledge
    input wire        wb_err_o,   // wishbone error
    input wire [31:0] wb_dat_o,   // wishbone read data
    input wire [7:0]  pa_in,      // port a pin levels
    input wire [7:0]  pc_oe,      // port c output enables
    input wire [7:0]  pc_pullup,  // port c pull-up enables
    input wire [7:0]  irq_req     // interrupt request inputs
);
    // ===========================================================
    // helper: cycles since reset release, saturating
    reg [2:0] up_cnt_reg;
    always @(posedge core_clk or posedge rst) begin
        if (rst)
            up_cnt_reg <= 3'h0;
        else if (up_cnt_reg != 3'h7)
            up_cnt_reg <= up_cnt_reg + 3'h1;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // ===========================================================
    // pin rules
    AST_PC_PU_INPUT: assert property ((pc_pullup & pc_oe) == 8'h00)
        else $error("pull-up on a driven port c pin");
    AST_PC_PU_HWSTBY: assert property (hw_standby [*5] |-> pc_pullup == 8'h00)
        else $error("port c pull-up on in hardware standby");
    AST_IRQ_PATH: assert property (up_cnt_reg == 3'h7 |-> irq_req[7:5] == $past(pa_in[7:5], 3))
        else $error("interrupt inputs do not follow port a pins");
    AST_IRQ_LOW: assert property (irq_req[3:0] == 4'h0)
        else $error("unused interrupt inputs active");
    // ===========================================================
    // bus answer rules
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_ANSWER: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o != wb_err_o)
        else $error("request not answered in one cycle");
    AST_NO_SPUR: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o && !wb_err_o)
        else $error("answer without request");
    AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    AST_DAT_UPPER: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper read data not zero");
endmodule
bind apl_port apl_port_checker chk_u (.core_clk(core_clk), .rst(rst), .hw_standby(hw_standby),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .wb_dat_o(wb_dat_o),
    .pa_in(pa_in), .pc_oe(pc_oe), .pc_pullup(pc_pullup), .irq_req(irq_req));

/* File: tb/apl_pin_model.sv */
// external pin model for one 8-bit port
`timescale 1ns/1ns
module apl_pin_model (
    input  wire       core_clk, // system clock
    input  wire [7:0] out_v,    // device output values
    input  wire [7:0] oe,       // device output enables
    input  wire [7:0] pu,       // device pull-up enables
    input  wire [7:0] ext_en,   // outside driver enables
    input  wire [7:0] ext_val,  // outside driver values
    output wire [7:0] pin       // resolved pin levels
);
    // ===========================================================
    // floating pins wander so a stale level never passes
    logic [7:0] wobble = 8'h00;
    always @(posedge core_clk) begin
        wobble <= wobble + 8'h5b;
    end
    // device drive, then outside drive, then weak pull-up, else floating
    assign pin = (oe & out_v) | (~oe & ext_en & ext_val) | (~oe & ~ext_en & pu)
               | (~oe & ~ext_en & ~pu & wobble);
endmodule

/* File: tb/tb.sv */
// testbench for the address port pin logic block
`timescale 1ns/1ns
`include "apl_consts.vh"
module tb;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic        hw_standby = 1'b0;
    logic [23:0] addr_in = 24'h0;
    logic        addr_valid = 1'b0;
    logic [31:0] wb_adr_i = 32'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic        wb_we_i = 1'b0;
    logic [3:0]  wb_sel_i = 4'h0;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic [7:0]  ext_en = 8'h00;
    logic [7:0]  ext_val = 8'h00;
    wire  [31:0] wb_dat_o;
    wire         wb_ack_o, wb_err_o;
    wire  [7:0]  pa_in, pa_out, pa_oe, pa_pullup, pb_in, pb_out, pb_oe, pb_pullup;
    wire  [7:0]  pc_in, pc_out, pc_oe, pc_pullup, pf_in, pf_out, pf_oe, irq_req;
    integer      fail_count = 0;
    integer      num_checks = 0;
    integer      cyc_cnt = 0;
    integer      i;
    logic [31:0] rd;
    logic        er;
    logic [7:0]  m;
    // ===========================================================
    // clock, design and pins
    always #50 core_clk = ~core_clk;
    apl_port dut_u (.core_clk(core_clk), .rst(rst), .hw_standby(hw_standby), .addr_in(addr_in),
        .addr_valid(addr_valid), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i),
        .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
        .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe), .pa_pullup(pa_pullup), .pb_in(pb_in), .pb_out(pb_out),
        .pb_oe(pb_oe), .pb_pullup(pb_pullup), .pc_in(pc_in), .pc_out(pc_out), .pc_oe(pc_oe),
        .pc_pullup(pc_pullup), .pf_in(pf_in), .pf_out(pf_out), .pf_oe(pf_oe), .irq_req(irq_req));
    apl_pin_model pa_u (.core_clk(core_clk), .out_v(pa_out), .oe(pa_oe), .pu(pa_pullup), .ext_en(ext_en),
        .ext_val(ext_val), .pin(pa_in));
    apl_pin_model pb_u (.core_clk(core_clk), .out_v(pb_out), .oe(pb_oe), .pu(pb_pullup), .ext_en(ext_en),
        .ext_val(ext_val), .pin(pb_in));
    apl_pin_model pc_u (.core_clk(core_clk), .out_v(pc_out), .oe(pc_oe), .pu(pc_pullup), .ext_en(ext_en),
        .ext_val(ext_val), .pin(pc_in));
    apl_pin_model pf_u (.core_clk(core_clk), .out_v(pf_out), .oe(pf_oe), .pu(8'h00), .ext_en(ext_en),
        .ext_val(ext_val), .pin(pf_in));
    // ===========================================================
    // tasks
    task wrap_up;
        begin
            $display("checks %0d mismatches %0d", num_checks, fail_count);
            if (fail_count == 0 && num_checks > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    // one classic wishbone cycle, held until ack or err is sampled
    task wb_xfer(input [7:0] a, input w, input [7:0] d);
        begin
            @(posedge core_clk);
            wb_cyc_i <= 1'b1;
            wb_stb_i <= 1'b1;
            wb_adr_i <= {24'h0, a};
            wb_we_i  <= w;
            wb_dat_i <= {24'h0, d};
            wb_sel_i <= 4'h1;
            @(posedge core_clk);
            while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1) @(posedge core_clk);
            rd = wb_dat_o;
            er = wb_err_o;
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
            wb_we_i  <= 1'b0;
        end
    endtask
    task chk_rd(input [31:0] got, input [31:0] exp);
        begin
            num_checks++;
            if (got !== exp) begin
                fail_count++;
                $display("wrong value at %0t: read %h expected %h", $time, got, exp);
            end
        end
    endtask
    task chk_pin(input [7:0] got, input [7:0] exp);
        begin
            num_checks++;
            if (got !== exp) begin
                fail_count++;
                $display("wrong value at %0t: pins %h expected %h", $time, got, exp);
            end
        end
    endtask
    task rd_chk(input [7:0] a, input [7:0] exp);
        begin
            wb_xfer(a, 1'b0, 8'h00);
            chk_rd(rd, {24'h0, exp});
        end
    endtask
    task settle;
        repeat (5) @(negedge core_clk);
    endtask
    // ===========================================================
    // timeout guard
    always @(posedge core_clk) begin
        cyc_cnt++;
        if (cyc_cnt == 5000) begin
            fail_count++;
            wrap_up;
        end
    end
    // ===========================================================
    // main sequence
    initial begin
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        rd_chk(`APL_OFF_MODE, 8'h07);
        rd_chk(`APL_OFF_PF_LATCH, 8'h00);
        wb_xfer(8'h48, 1'b0, 8'h00);
        chk_pin({7'h0, er}, 8'h01);
        wb_xfer(`APL_OFF_PF_DIR, 1'b1, 8'hff);
        wb_xfer(`APL_OFF_PF_LATCH, 1'b1, 8'ha5);
        settle;
        chk_pin(pf_out, 8'ha5);
        chk_pin(pf_oe, 8'hff);
        wb_xfer(`APL_OFF_PF_DIR, 1'b1, 8'h0f);
        ext_en <= 8'hff;
        ext_val <= 8'h3c;
        settle;
        rd_chk(`APL_OFF_PF_PIN, 8'h35);
        wb_xfer(`APL_OFF_PF_PIN, 1'b1, 8'h00);
        rd_chk(`APL_OFF_PF_LATCH, 8'ha5);
        chk_pin(pf_oe, 8'h0f);
        ext_en <= 8'h00;
        // port c pull-ups in modes 7 and 4, normal, software and hardware standby
        for (i = 0; i < 2; i++) begin
            m = (i == 0) ? 8'h07 : 8'h04;
            wb_xfer(`APL_OFF_MODE, 1'b1, m);
            wb_xfer(`APL_OFF_PC_DIR, 1'b1, 8'hf0);
            wb_xfer(`APL_OFF_PC_PULLUP, 1'b1, 8'h3c);
            settle;
            chk_pin(pc_pullup, 8'h0c);
            chk_pin(pc_oe, 8'hf0);
            wb_xfer(`APL_OFF_MODE, 1'b1, m | 8'h10);
            settle;
            chk_pin(pc_pullup, 8'h0c);
            @(posedge core_clk);
            hw_standby <= 1'b1;
            settle;
            chk_pin(pc_pullup, 8'h00);
            @(posedge core_clk);
            hw_standby <= 1'b0;
        end
        // address modes with the bus controller presenting an address
        addr_in <= 24'hb23456;
        addr_valid <= 1'b1;
        ext_en <= 8'hff;
        ext_val <= 8'hf0;
        for (i = 1; i < 3; i++) begin
            wb_xfer(`APL_OFF_MODE, 1'b1, i[7:0]);
            settle;
            chk_pin(pc_pullup, 8'h00);
            chk_pin(pc_out, 8'h56);
            chk_pin(pb_out, 8'h34);
            chk_pin(pb_oe, 8'hff);
            chk_pin(pc_oe, 8'hff);
            chk_pin(pa_out & 8'h1f, 8'h12);
            chk_pin(irq_req, 8'he0);
        end
        // mixed mode: only output pins carry the address
        wb_xfer(`APL_OFF_PA_DIR, 1'b1, 8'hff);
        wb_xfer(`APL_OFF_MODE, 1'b1, 8'h0f);
        settle;
        chk_pin(pc_out, 8'h50);
        chk_pin(pc_oe, 8'hf0);
        chk_pin(pa_out, 8'hb2);
        chk_pin(pa_oe, 8'hff);
        chk_pin(irq_req, 8'hb0);
        wb_xfer(`APL_OFF_PA_DIR, 1'b1, 8'h00);
        wb_xfer(`APL_OFF_MODE, 1'b1, 8'h07);
        wb_xfer(`APL_OFF_PA_PULLUP, 1'b1, 8'hff);
        wb_xfer(`APL_OFF_PB_PULLUP, 1'b1, 8'hff);
        settle;
        chk_pin(pc_oe, 8'hf0);
        chk_pin(irq_req, 8'hf0);
        chk_pin(pa_pullup, 8'hff);
        chk_pin(pb_pullup, 8'hff);
        wrap_up;
    end
endmodule
